// [hw/acp_consts.svh]
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH
// ****************************************************************
// timing figures and derived cycle counts at 100 MHz
// ****************************************************************
`define ACP_CLK_NS 100'd10
`define ACP_DEEP_WAKE_MS 10
`define ACP_LIGHT_WAKE_NS 200
`define ACP_CONV_MAX_NS 750
`define ACP_ACQ_NS 150
`define ACP_PULSE_NS 40
`define ACP_DEEP_WAKE_CYC ((`ACP_DEEP_WAKE_MS * 1000000 + 9) / 10)
`define ACP_LIGHT_WAKE_CYC ((`ACP_LIGHT_WAKE_NS + 9) / 10)
`define ACP_CONV_MAX_CYC ((`ACP_CONV_MAX_NS + 9) / 10)
`define ACP_ACQ_CYC ((`ACP_ACQ_NS + 9) / 10)
`define ACP_PULSE_CYC ((`ACP_PULSE_NS + 9) / 10)
`define ACP_CNT_W 20
`define ACP_DATA_W 12
`endif

// [hw/acp_ctrl.sv]
`include "acp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module acp_ctrl (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire acp_pkg::acp_mode_t mode_in,
   input wire logic start_in,
   input wire logic sleep_in,
   input wire logic light_in,
   input wire logic busy_n_in,
   input wire logic [11:0] data_in,
   output acp_pkg::acp_pins_t pins_out,
   output logic ready_out,
   output logic result_valid_out,
   output logic [11:0] result_out,
   output logic timeout_out
);
   // ****************************************************************
   // sequencer states
   // ****************************************************************
   typedef enum logic [2:0] {
      ACP_ST_WAKE,
      ACP_ST_IDLE,
      ACP_ST_PULSE,
      ACP_ST_CONV,
      ACP_ST_READ,
      ACP_ST_ACQ,
      ACP_ST_SLEEP
   } acp_state_t;

   acp_state_t state_reg, state_next;
   logic [`ACP_CNT_W-1:0] cnt_reg, cnt_next;
   logic [11:0] result_reg, result_next;
   logic valid_reg, valid_next;
   logic tmo_reg, tmo_next;
   logic busy_d_reg, busy_d_next;
   logic cs_reg, cs_next;
   logic rd_reg, rd_next;
   logic cv_reg, cv_next;
   logic pd_reg, pd_next;
   logic light_reg, light_next;
   logic busy_rise;

   assign busy_rise = busy_n_in & ~busy_d_reg;

   // ****************************************************************
   // next state and pin values
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      result_next = result_reg;
      valid_next = 1'b0;
      tmo_next = tmo_reg;
      busy_d_next = busy_n_in;
      cs_next = 1'b0;
      rd_next = rd_reg;
      cv_next = cv_reg;
      pd_next = pd_reg;
      light_next = light_reg;
      if (cnt_reg != '0) begin
         cnt_next = cnt_reg - 1'b1;
      end
      case (state_reg)
         ACP_ST_WAKE: begin
            pd_next = 1'b1;
            cv_next = 1'b1;
            rd_next = (mode_in == acp_pkg::ACP_MODE_FREE) ? 1'b0 : 1'b1;
            if (cnt_reg == '0) begin
               state_next = ACP_ST_IDLE;
            end
         end
         ACP_ST_IDLE: begin
            rd_next = (mode_in == acp_pkg::ACP_MODE_FREE) ? 1'b0 : 1'b1;
            cv_next = 1'b1;
            if (sleep_in) begin
               // light selection must settle before power_down_n falls
               light_next = light_in;
               state_next = ACP_ST_SLEEP;
               cnt_next = `ACP_CNT_W'(`ACP_PULSE_CYC);
            end else if (start_in) begin
               cv_next = 1'b0;
               tmo_next = 1'b0;
               if (mode_in == acp_pkg::ACP_MODE_SLOWMEM ||
                   mode_in == acp_pkg::ACP_MODE_ROM) begin
                  rd_next = 1'b0;
               end
               cnt_next = `ACP_CNT_W'(`ACP_PULSE_CYC);
               state_next = ACP_ST_PULSE;
            end
         end
         ACP_ST_PULSE: begin
            if (cnt_reg == '0) begin
               // rom strobe reads the previous result as it ends
               if (mode_in == acp_pkg::ACP_MODE_ROM) begin
                  result_next = data_in;
                  valid_next = 1'b1;
               end
               // slow memory keeps the combined strobe low while busy
               if (mode_in != acp_pkg::ACP_MODE_SLOWMEM) begin
                  cv_next = 1'b1;
                  rd_next = (mode_in == acp_pkg::ACP_MODE_FREE) ? 1'b0 : 1'b1;
               end
               cnt_next = `ACP_CNT_W'(`ACP_CONV_MAX_CYC + 4);
               state_next = ACP_ST_CONV;
            end
         end
         ACP_ST_CONV: begin
            if (busy_rise && cnt_reg < `ACP_CNT_W'(`ACP_CONV_MAX_CYC + 2)) begin
               if (mode_in == acp_pkg::ACP_MODE_STROBED) begin
                  rd_next = 1'b0;
                  cnt_next = `ACP_CNT_W'(`ACP_PULSE_CYC);
                  state_next = ACP_ST_READ;
               end else begin
                  // capture on busy rising edge; rom read it already
                  if (mode_in != acp_pkg::ACP_MODE_ROM) begin
                     result_next = data_in;
                     valid_next = 1'b1;
                  end
                  cv_next = 1'b1;
                  rd_next = (mode_in == acp_pkg::ACP_MODE_FREE) ? 1'b0 : 1'b1;
                  cnt_next = `ACP_CNT_W'(`ACP_ACQ_CYC);
                  state_next = ACP_ST_ACQ;
               end
            end else if (cnt_reg == '0) begin
               tmo_next = 1'b1;
               cv_next = 1'b1;
               rd_next = (mode_in == acp_pkg::ACP_MODE_FREE) ? 1'b0 : 1'b1;
               cnt_next = `ACP_CNT_W'(`ACP_ACQ_CYC);
               state_next = ACP_ST_ACQ;
            end
         end
         ACP_ST_READ: begin
            if (cnt_reg == '0) begin
               result_next = data_in;
               valid_next = 1'b1;
               rd_next = 1'b1;
               cnt_next = `ACP_CNT_W'(`ACP_ACQ_CYC);
               state_next = ACP_ST_ACQ;
            end
         end
         ACP_ST_ACQ: begin
            if (cnt_reg == '0) begin
               state_next = ACP_ST_IDLE;
            end
         end
         ACP_ST_SLEEP: begin
            if (cnt_reg == '0) begin
               pd_next = 1'b0;
            end
            if (!sleep_in && !pd_reg) begin
               pd_next = 1'b1;
               // wake time depends on standby depth
               cnt_next = light_reg ? `ACP_CNT_W'(`ACP_LIGHT_WAKE_CYC)
                                    : `ACP_CNT_W'(`ACP_DEEP_WAKE_CYC);
               state_next = ACP_ST_WAKE;
            end
         end
         default: begin
            state_next = ACP_ST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // state registers
   // ****************************************************************
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg <= ACP_ST_WAKE;
         cnt_reg <= '0;
         result_reg <= 12'h000;
         valid_reg <= 1'b0;
         tmo_reg <= 1'b0;
         busy_d_reg <= 1'b1;
         cs_reg <= 1'b1;
         rd_reg <= 1'b1;
         cv_reg <= 1'b1;
         pd_reg <= 1'b1;
         light_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         result_reg <= result_next;
         valid_reg <= valid_next;
         tmo_reg <= tmo_next;
         busy_d_reg <= busy_d_next;
         cs_reg <= cs_next;
         rd_reg <= rd_next;
         cv_reg <= cv_next;
         pd_reg <= pd_next;
         light_reg <= light_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign pins_out.convert_start_n = cv_reg;
   assign pins_out.select_n = cs_reg;
   assign pins_out.read_n = rd_reg;
   assign pins_out.power_down_n = pd_reg;
   assign pins_out.standby_depth_select = light_reg;
   assign ready_out = (state_reg == ACP_ST_IDLE);
   assign result_valid_out = valid_reg;
   assign result_out = result_reg;
   assign timeout_out = tmo_reg;
endmodule
`default_nettype wire

// [hw/acp_pkg.sv]
package acp_pkg;
   // ****************************************************************
   // operating arrangements and pin bundles
   // ****************************************************************
   typedef enum logic [1:0] {
      ACP_MODE_FREE,
      ACP_MODE_STROBED,
      ACP_MODE_SLOWMEM,
      ACP_MODE_ROM
   } acp_mode_t;

   typedef struct packed {
      logic convert_start_n;
      logic select_n;
      logic read_n;
      logic power_down_n;
      logic standby_depth_select;
   } acp_pins_t;
endpackage

// [tb/acp_adc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module acp_adc_model (
   input wire acp_pkg::acp_pins_t pins_in,
   output logic busy_n_out,
   output logic [11:0] data_out
);
   int conv_ns = 700;
   logic [11:0] res_reg = 12'h000;
   logic [11:0] code_reg = 12'h5a3;
   initial busy_n_out = 1'b1;
   // start on a falling strobe only when selected, awake and idle
   always @(negedge pins_in.convert_start_n) begin
      if (!pins_in.select_n && pins_in.power_down_n && busy_n_out) begin
         busy_n_out = 1'b0;
         #(conv_ns);
         res_reg = code_reg;
         code_reg = code_reg + 12'h1;
         #1 busy_n_out = 1'b1;
      end
   end
   // released bus shows the inverse of the last value
   assign data_out = (!pins_in.select_n && !pins_in.read_n) ? res_reg : ~res_reg;
endmodule
`default_nettype wire

// [tb/acp_ctrl_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module acp_ctrl_checker (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire acp_pkg::acp_mode_t mode_in,
   input wire logic start_in,
   input wire logic sleep_in,
   input wire logic busy_n_in,
   input wire logic [11:0] data_in,
   input wire acp_pkg::acp_pins_t pins_out,
   input wire logic ready_out,
   input wire logic result_valid_out,
   input wire logic [11:0] result_out,
   input wire logic timeout_out
);
   // *********
   // port laws
   // *********
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   a_select_held: assert property (
      $fell(pins_out.convert_start_n) |-> !pins_out.select_n)
      else $error("strobe without select");
   a_take_strobe: assert property (
      ready_out && start_in && !sleep_in |=> !pins_out.convert_start_n)
      else $error("take gave no strobe");
   a_pulse_len: assert property (
      $fell(pins_out.convert_start_n) && mode_in != acp_pkg::ACP_MODE_SLOWMEM
      |-> !pins_out.convert_start_n [*5] ##1 pins_out.convert_start_n)
      else $error("strobe width wrong");
   a_capture_data: assert property (
      result_valid_out && mode_in != acp_pkg::ACP_MODE_STROBED
      |-> result_out == $past(data_in))
      else $error("captured wrong data");
   a_result_hold: assert property (
      !result_valid_out |-> $stable(result_out))
      else $error("result moved");
   a_acq_gap: assert property (
      result_valid_out |-> ##14 !ready_out)
      else $error("acquisition too short");
   a_wait_busy: assert property (
      mode_in == acp_pkg::ACP_MODE_SLOWMEM && !pins_out.read_n && !busy_n_in
      |=> !pins_out.read_n)
      else $error("read released while busy");
   a_light_wake: assert property (
      $rose(pins_out.power_down_n) |-> ##18 !ready_out)
      else $error("wake too short");
   a_strobe_read: assert property (
      mode_in == acp_pkg::ACP_MODE_STROBED && $fell(pins_out.read_n)
      |-> busy_n_in)
      else $error("read during conversion");
   c_rom: cover property (result_valid_out && mode_in == acp_pkg::ACP_MODE_ROM);
   c_timeout: cover property ($rose(timeout_out));
   c_nap: cover property ($fell(pins_out.power_down_n));
endmodule
bind acp_ctrl acp_ctrl_checker chk_u (.core_clk_in, .nrst_in, .mode_in,
   .start_in, .sleep_in, .busy_n_in, .data_in, .pins_out, .ready_out,
   .result_valid_out, .result_out, .timeout_out);
`default_nettype wire

// [tb/test_acp_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module test_acp_ctrl;
   logic core_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   acp_pkg::acp_mode_t mode_in = acp_pkg::ACP_MODE_FREE;
   logic start_in = 1'b0;
   logic sleep_in = 1'b0;
   logic light_in = 1'b1;
   logic busy_n_in;
   logic [11:0] data_in;
   acp_pkg::acp_pins_t pins_out;
   logic ready_out;
   logic result_valid_out;
   logic [11:0] result_out;
   logic timeout_out;
   logic [11:0] exp_code = 12'h5a3;
   logic [11:0] last_out = 12'h000;
   logic [11:0] want;
   int err_total = 0;
   int cmp_count = 0;
   // **************
   // clock and parts
   // **************
   always #5 core_clk_in = ~core_clk_in;
   acp_ctrl dut_u (.core_clk_in, .nrst_in, .mode_in, .start_in, .sleep_in,
      .light_in, .busy_n_in, .data_in, .pins_out, .ready_out,
      .result_valid_out, .result_out, .timeout_out);
   acp_adc_model dev_u (.pins_in(pins_out), .busy_n_out(busy_n_in),
      .data_out(data_in));
   task automatic check(input string name, input logic [11:0] seen,
      input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wait_ready(input int lim);
      for (int n = 0; n < lim && ready_out !== 1'b1; n++) @(negedge core_clk_in);
      check("ready", {11'h0, ready_out}, 12'h001);
   endtask
   // one conversion; a slow device past the limit must time out
   task automatic convert(input acp_pkg::acp_mode_t m, input int ns);
      dev_u.conv_ns = ns;
      wait_ready(100);
      @(posedge core_clk_in);
      mode_in <= m;
      start_in <= 1'b1;
      @(posedge core_clk_in);
      start_in <= 1'b0;
      for (int n = 0; n < 120 && result_valid_out !== 1'b1; n++) @(negedge core_clk_in);
      check("timeout", {11'h0, timeout_out}, {11'h0, ns > 900});
      // rom hands back the previous result; a timeout keeps the old one
      want = (ns > 900) ? last_out :
         (m == acp_pkg::ACP_MODE_ROM) ? exp_code - 12'h1 : exp_code;
      check("result", result_out, want);
      last_out = want;
      exp_code = exp_code + 12'h1;
   endtask
   // sleep with a start pending, which sleep must win
   task automatic nap(input logic light);
      int n;
      wait_ready(100);
      @(posedge core_clk_in);
      sleep_in <= 1'b1;
      light_in <= light;
      start_in <= 1'b1;
      repeat (8) @(negedge core_clk_in);
      check("sleep pins", {9'h0, pins_out.convert_start_n, pins_out.power_down_n, pins_out.standby_depth_select}, {10'h2, light});
      @(posedge core_clk_in);
      sleep_in <= 1'b0;
      start_in <= 1'b0;
      for (n = 0; n < (light ? 100 : 2000) && ready_out !== 1'b1; n++) @(negedge core_clk_in);
      if (light) begin
         check("light wake", {11'h0, n >= 20}, 12'h001);
      end else begin
         check("deep wake", {11'h0, ready_out}, 12'h000);
      end
   endtask
   task automatic tally_and_finish();
      if (err_total == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // watchdog well past the longest expected run
   initial begin
      #100_000;
      err_total++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      repeat (2) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      wait_ready(10);
      convert(acp_pkg::ACP_MODE_FREE, 700);
      convert(acp_pkg::ACP_MODE_STROBED, 100);
      convert(acp_pkg::ACP_MODE_SLOWMEM, 740);
      convert(acp_pkg::ACP_MODE_ROM, 700);
      convert(acp_pkg::ACP_MODE_FREE, 1000);
      convert(acp_pkg::ACP_MODE_ROM, 300);
      nap(1'b1);
      convert(acp_pkg::ACP_MODE_SLOWMEM, 700);
      nap(1'b0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
